// ### logic/quiesce_pkg.sv
package quiesce_pkg;
  // ------------------------------------------------------------
  // register map, byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] CAP_STATUS_TWO_OFS = 8'h00;
  localparam logic [7:0] CONTROL_TWO_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

  // ------------------------------------------------------------
  // field positions and widths
  // ------------------------------------------------------------
  localparam int ACK_BIT = 14;
  localparam int CAP_BIT = 15;
  localparam int REQ_BIT = 0;
  localparam int SCALE_LSB = 8;
  localparam int SCALE_W = 3;
  localparam int VALUE_LSB = 16;
  localparam int VALUE_W = 9;
  localparam int TICKS_W = 16;
  localparam int IRQ_W = 2;
  localparam int IRQ_ACK_BIT = 0;
  localparam int IRQ_LATE_BIT = 1;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [SCALE_W-1:0] SCALE_RST = 3'h0;
  localparam logic [VALUE_W-1:0] VALUE_RST = 9'h000;
  localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

  // ------------------------------------------------------------
  // timing: one quiesce time unit, in ns and in mclk cycles
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int QUIESCE_UNIT_NS = 1024;
  localparam int UNIT_CYCLES_INT = QUIESCE_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] UNIT_CYCLES = 8'(UNIT_CYCLES_INT);
endpackage : quiesce_pkg

// ### logic/device_quiesce_handshake.sv
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - quiesce_ack is read-only bit 14 of common_cap_status_two, 1 = quiesced
// - when hardware-capable, ack follows the device's own quiesce mechanism
// - else ack rises only after request seen and idle a full quiesce time
// - quiesce time comes from time-scale and time-value control fields
// - ack rises within twice the quiesce time after request rises if idle; else a late event is flagged
// - request falling clears ack back to zero
// - bit 15 reports hardware quiesce acknowledge capability, read-only
module device_quiesce_handshake (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_quiesce_ack_capable,
  input wire logic hw_quiesce_acknowledge,
  input wire logic req_pending,
  input wire logic resp_outstanding,
  output logic req_issue,
  output logic quiesce_request,
  output logic irq
);
  import quiesce_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic [quiesce_pkg::SCALE_W-1:0] scale;
    logic [quiesce_pkg::VALUE_W-1:0] value;
    logic cap;
    logic ack;
    logic [7:0] idle_pre;
    logic [quiesce_pkg::TICKS_W-1:0] idle_ticks;
    logic [7:0] el_pre;
    logic [quiesce_pkg::TICKS_W:0] el_ticks;
    logic late_done;
    logic was_busy;
    logic [quiesce_pkg::IRQ_W-1:0] irq_stat;
    logic [quiesce_pkg::IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [TICKS_W-1:0] target;
  logic busy;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic [IRQ_W-1:0] ev;

  // decode used only for the error answer; read data has its own case
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CAP_STATUS_TWO_OFS) || (a == CONTROL_TWO_OFS) ||
             (a == IRQ_STATUS_OFS) || (a == IRQ_MASK_OFS);
  endfunction : mapped

  // ------------------------------------------------------------
  // combinational helpers
  // ------------------------------------------------------------
  // quiesce time in units: value shifted by scale
  assign target = TICKS_W'({7'h00, s_q.value} << s_q.scale);
  // blocking issue while quiescing lets the idle state be reached
  assign req_issue = req_pending & ~s_q.req;
  assign busy = req_issue | resp_outstanding;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata = s_q.rdata;
  assign quiesce_request = s_q.req;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    ev = '0;
    // strap sampled every cycle, never at reset
    s_d.cap = hw_quiesce_ack_capable;
    // control write takes effect at the access edge
    if (wr_acc && paddr == CONTROL_TWO_OFS)
    begin
      s_d.req = pwdata[REQ_BIT];
      s_d.scale = pwdata[SCALE_LSB +: SCALE_W];
      s_d.value = pwdata[VALUE_LSB +: VALUE_W];
    end
    if (wr_acc && paddr == IRQ_MASK_OFS)
    begin
      s_d.irq_mask = pwdata[IRQ_W-1:0];
    end
    // read data captured in the setup cycle so it is stable in access
    if (setup)
    begin
      s_d.rdata = '0;
      unique case (paddr)
        CAP_STATUS_TWO_OFS:
        begin
          s_d.rdata[ACK_BIT] = s_q.ack;
          s_d.rdata[CAP_BIT] = s_q.cap;
        end
        CONTROL_TWO_OFS:
        begin
          s_d.rdata[REQ_BIT] = s_q.req;
          s_d.rdata[SCALE_LSB +: SCALE_W] = s_q.scale;
          s_d.rdata[VALUE_LSB +: VALUE_W] = s_q.value;
        end
        IRQ_STATUS_OFS: s_d.rdata[IRQ_W-1:0] = s_q.irq_stat;
        IRQ_MASK_OFS: s_d.rdata[IRQ_W-1:0] = s_q.irq_mask;
        default: s_d.rdata = '0;
      endcase
    end
    if (!s_q.req)
    begin
      // withdrawn request clears ack and all counters
      s_d.ack = 1'b0;
      s_d.idle_pre = '0;
      s_d.idle_ticks = '0;
      s_d.el_pre = '0;
      s_d.el_ticks = '0;
      s_d.late_done = 1'b0;
      s_d.was_busy = 1'b0;
    end
    else
    begin
      if (busy)
      begin
        s_d.was_busy = 1'b1;
      end
      // elapsed time since the request rose, for the late flag
      if (s_q.el_pre == UNIT_CYCLES - 8'h01)
      begin
        s_d.el_pre = '0;
        if (s_q.el_ticks != {1'b0, target} << 1)
        begin
          s_d.el_ticks = s_q.el_ticks + 1'b1;
        end
      end
      else
      begin
        s_d.el_pre = s_q.el_pre + 8'h01;
      end
      // twice the quiesce time passed with no ack: report once
      if (!s_q.ack && !s_q.late_done &&
          s_q.el_ticks == ({1'b0, target} << 1))
      begin
        s_d.late_done = 1'b1;
        ev[IRQ_LATE_BIT] = 1'b1;
      end
      if (s_q.cap)
      begin
        // own mechanism drives ack directly
        s_d.ack = hw_quiesce_acknowledge;
      end
      else if (busy)
      begin
        // any activity starts the idle time over
        s_d.idle_pre = '0;
        s_d.idle_ticks = '0;
      end
      else if (!s_q.ack)
      begin
        if (s_q.idle_ticks == target)
        begin
          s_d.ack = 1'b1;
        end
        else if (s_q.idle_pre == UNIT_CYCLES - 8'h01)
        begin
          s_d.idle_pre = '0;
          s_d.idle_ticks = s_q.idle_ticks + 1'b1;
        end
        else
        begin
          s_d.idle_pre = s_q.idle_pre + 8'h01;
        end
      end
    end
    if (s_d.ack && !s_q.ack)
    begin
      ev[IRQ_ACK_BIT] = 1'b1;
    end
    // read of status clears it, but a new event in the same edge wins
    if (rd_acc && paddr == IRQ_STATUS_OFS)
    begin
      s_d.irq_stat = ev;
    end
    else
    begin
      s_d.irq_stat = s_q.irq_stat | ev;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.scale <= SCALE_RST;
      s_q.value <= VALUE_RST;
      s_q.irq_mask <= MASK_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_ack_readback: assert property (@(posedge mclk) disable iff (rst)
    setup && paddr == CAP_STATUS_TWO_OFS |=> prdata[ACK_BIT] == $past(s_q.ack))
    else $error("ack bit read back wrong");
  chk_hw_path: assert property (@(posedge mclk) disable iff (rst)
    s_q.req && s_q.cap |=> s_q.ack == $past(hw_quiesce_acknowledge))
    else $error("hardware ack not followed");
  chk_ack_after_idle: assert property (@(posedge mclk)
    disable iff (rst)
    $rose(s_q.ack) && !$past(s_q.cap) |->
      $past(s_q.idle_ticks) == $past(target) && !$past(busy))
    else $error("ack rose before idle time");
  chk_time_bound: assert property (@(posedge mclk) disable iff (rst)
    s_q.req && !s_q.cap |-> s_q.idle_ticks <= target)
    else $error("idle count passed quiesce time");
  chk_ack_deadline: assert property (@(posedge mclk) disable iff (rst)
    s_q.req && !s_q.cap && !s_q.was_busy && !busy &&
      s_q.el_ticks == ({1'b0, target} << 1) && s_q.el_ticks != '0
      |-> s_q.ack)
    else $error("ack missed twice quiesce time");
  chk_ack_clear: assert property (@(posedge mclk) disable iff (rst)
    $fell(s_q.req) |=> !s_q.ack ##1 !s_q.ack || s_q.req)
    else $error("ack not cleared on withdraw");
  chk_cap_report: assert property (@(posedge mclk) disable iff (rst)
    setup && paddr == CAP_STATUS_TWO_OFS |=>
      prdata[CAP_BIT] == $past(s_q.cap))
    else $error("capability bit wrong");
  chk_idle_restart: assert property (@(posedge mclk) disable iff (rst)
    s_q.req && !s_q.cap && busy |=> s_q.idle_ticks == '0)
    else $error("idle count not restarted");
  chk_no_issue: assert property (@(posedge mclk) disable iff (rst)
    s_q.req |-> !req_issue)
    else $error("request issued while quiescing");
endmodule : device_quiesce_handshake

// ### verif/sw_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// software side: apb master, expected reads kept in a queue
// ------------------------------------------------------------
module sw_host (
  input wire logic mclk,
  input wire logic pready,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0
);
  logic [32:0] exp_q[$];

  // request held until pready is sampled high; no fixed wait assumed
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // single read; the note {pslverr, prdata} is queued first
  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
endmodule : sw_host

// ### verif/testbench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench: apb software model, random core traffic, queued checks
// ------------------------------------------------------------
module testbench;
  import quiesce_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b0;
  logic hw_ack = 1'b0;
  logic req_pending = 1'b0;
  logic resp_out = 1'b0;
  logic qreq = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, req_issue, quiesce_request;
  logic irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int n_fail = 0;
  int comparisons = 0;
  int seed = 85;

  always #4 mclk = ~mclk;

  sw_host sw (.mclk(mclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  device_quiesce_handshake dut (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_quiesce_ack_capable(strap), .hw_quiesce_acknowledge(hw_ack),
    .req_pending(req_pending), .resp_outstanding(resp_out),
    .req_issue(req_issue), .quiesce_request(quiesce_request), .irq(irq));

  task chk(input string n, input logic [32:0] e, input logic [32:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wrap_up;
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // expected word of the capability/status register
  function automatic logic [32:0] st(input logic c, input logic a);
    return {17'h0, c, a, 14'h0};
  endfunction : st

  task ctl(input logic [2:0] s, input logic [8:0] v, input logic r);
    sw.xfer(1'b1, CONTROL_TWO_OFS, {7'h0, v, 5'h0, s, 7'h0, r});
    qreq = r;
  endtask : ctl

  // random core traffic; gating must hide it while quiescing
  always @(posedge mclk)
    req_pending <= 1'($random(seed));

  // outputs are looked at mid-cycle, where they have settled
  always @(negedge mclk)
    if (!rst)
    begin
      chk("req_issue", {32'h0, req_pending & ~qreq}, 33'(req_issue));
      chk("quiesce_request", {32'h0, qreq}, 33'(quiesce_request));
    end

  // oldest note is compared when a read completes
  always @(posedge mclk)
    if (psel && penable && pready && !pwrite && sw.exp_q.size() > 0)
      chk("read", sw.exp_q.pop_front(), {pslverr, prdata});

  initial
  begin
    #200000;
    n_fail++;
    wrap_up();
  end

  initial
  begin
    cyc(20);
    rst <= 1'b0;
    sw.rd(CAP_STATUS_TWO_OFS, st(1'b0, 1'b0));
    sw.rd(CONTROL_TWO_OFS, 33'h0);
    sw.rd(IRQ_MASK_OFS, 33'h0);
    sw.rd(8'h10, {1'b1, 32'h0});
    sw.xfer(1'b1, IRQ_MASK_OFS, 32'h3);
    // scale 1 value 1: 256 idle cycles before ack
    ctl(3'h1, 9'h001, 1'b1);
    cyc(200);
    sw.rd(CAP_STATUS_TWO_OFS, st(1'b0, 1'b0));
    cyc(80);
    sw.rd(CAP_STATUS_TWO_OFS, st(1'b0, 1'b1));
    chk("irq", 33'h1, {32'h0, irq});
    sw.rd(IRQ_STATUS_OFS, 33'h1);
    // the clear lands at the access edge; look one edge later
    cyc(1);
    chk("irq", 33'h0, {32'h0, irq});
    ctl(3'h0, 9'h000, 1'b0);
    sw.rd(CAP_STATUS_TWO_OFS, st(1'b0, 1'b0));
    // outstanding responses hold off the count, which then restarts
    resp_out <= 1'b1;
    ctl(3'h0, 9'h001, 1'b1);
    cyc(100);
    resp_out <= 1'b0;
    cyc(100);
    sw.rd(CAP_STATUS_TWO_OFS, st(1'b0, 1'b0));
    cyc(40);
    sw.rd(CAP_STATUS_TWO_OFS, st(1'b0, 1'b1));
    sw.rd(IRQ_STATUS_OFS, 33'h1);
    ctl(3'h0, 9'h000, 1'b0);
    // busy past twice the time: late event reported
    resp_out <= 1'b1;
    ctl(3'h0, 9'h001, 1'b1);
    cyc(300);
    chk("irq", 33'h1, {32'h0, irq});
    sw.rd(IRQ_STATUS_OFS, 33'h2);
    sw.rd(CAP_STATUS_TWO_OFS, st(1'b0, 1'b0));
    resp_out <= 1'b0;
    ctl(3'h0, 9'h000, 1'b0);
    // hardware-capable device: ack follows its own mechanism
    strap <= 1'b1;
    ctl(3'h0, 9'h001, 1'b1);
    cyc(3);
    sw.rd(CAP_STATUS_TWO_OFS, st(1'b1, 1'b0));
    hw_ack <= 1'b1;
    cyc(3);
    sw.rd(CAP_STATUS_TWO_OFS, st(1'b1, 1'b1));
    ctl(3'h0, 9'h000, 1'b0);
    hw_ack <= 1'b0;
    cyc(3);
    sw.rd(CAP_STATUS_TWO_OFS, st(1'b1, 1'b0));
    cyc(5);
    wrap_up();
  end
endmodule : testbench
